// ---- virs_consts.svh ----
/*
 * Constants for the video input routing and battery-short sense control block.
 * Assumes inclusion by the control module only.
 */
`ifndef VIRS_CONSTS_SVH
`define VIRS_CONSTS_SVH

// ****************************************************************
// Register offsets (printed offsets are not all multiples of four)
// ****************************************************************
`define VIRS_IDX_ROUTING     8'h00
`define VIRS_IDX_SENSE_ONE   8'h5d
`define VIRS_IDX_SENSE_TWO   8'h5e
`define VIRS_IDX_IRQ_STATUS  8'h70
`define VIRS_IDX_IRQ_CLEAR   8'h71
`define VIRS_IDX_IRQ_ENABLE  8'h72
`define VIRS_IDX_ROUTE_STATE 8'h73

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define VIRS_SEL_MSB         4
`define VIRS_PWR_OFF_BIT     6
`define VIRS_THR_MSB         4
`define VIRS_THR_LSB         2
`define VIRS_RST_SELECT      5'h00
`define VIRS_RST_PWR_OFF     1'h1
`define VIRS_RST_THRESHOLD   3'h3
`define VIRS_SEL_LAST_VALID  5'h11
`define VIRS_SEL_SVIDEO      5'h08
`define VIRS_SEL_COMP        5'h0c
`define VIRS_SEL_DIFF        5'h0e

`endif

// ---- virs_pkg.sv ----
/*
 * Types for the video input routing and battery-short sense control block.
 * Assumes the constants header sits in the same folder.
 */
`default_nettype none
package virs_pkg;
    typedef enum logic [2:0] {
        VIRS_FMT_NONE   = 3'b000,
        VIRS_FMT_CVBS   = 3'b001,
        VIRS_FMT_SVIDEO = 3'b010,
        VIRS_FMT_COMP   = 3'b011,
        VIRS_FMT_DIFF   = 3'b100
    } virs_format_e;
endpackage
`default_nettype wire

// ---- virs_control.sv ----
/*
 * Input routing select and battery-short sense control, Avalon-MM slave.
 * Assumes synchronous comparator outputs from the analog sense front end.
 */
// Decided for this implementation: the Avalon-MM interface to the registers.
// Behaviour
// [RQ1] Five-bit format select; codes 10010-11111 reserved
// [RQ2] Codes 0-7 route composite on one input
// [RQ3] Codes 8-11 route S-Video on pairs
// [RQ4] Codes 12-13 route component on triples
// [RQ5] Codes 14-17 route differential composite pairs
// [RQ6] Format configures processor; unused channels powered down
// [RQ7] Exceeded threshold flags event, asserts interrupt low
// [RQ8] Status shows which sense pin tripped
// [RQ9] Diagnostics disabled after reset
// [RQ10] First comparator power-off bit, reset one
// [RQ11] First comparator three-bit threshold field
// [RQ12] Software powers comparator before trusting threshold
// [RQ13] Threshold codes 75mV-1.125V, reset code 011
// [RQ14] Second comparator register, same layout
// [RQ15] Reserved code powers everything down, routes nothing
`default_nettype none
`include "virs_consts.svh"

module virs_control
    import virs_pkg::*;
#(
    parameter int INPUTS = 8
) (
    input  wire logic         mclk,
    input  wire logic         reset_n,
    input  wire logic [7:0]   avAddress,
    input  wire logic         avRead,
    input  wire logic         avWrite,
    input  wire logic [31:0]  avWriteData,
    output logic      [31:0]  avReadData,
    output logic              avWaitRequest,
    input  wire logic [1:0]   senseAboveThreshold,
    output logic      [1:0]   sensePowerOff,
    output logic      [5:0]   senseThreshold,
    output logic [INPUTS-1:0] channelPowerOn,
    output logic [INPUTS-1:0] routeToConverter,
    output virs_format_e      processorFormat,
    output logic              interrupt_request_n
);
    // Only the eight-input routing table is built here
    if (INPUTS != 8) begin : gBadInputs
        $error("virs_control serves eight analog inputs only");
    end

    logic [4:0]   inputFormatSelect;
    logic [1:0]   powerOff;
    logic [2:0]   threshold [2];
    logic [1:0]   irqStatus;
    logic [1:0]   irqEnable;
    logic         ackPending;
    logic         takeWrite;
    logic [1:0]   clearHits;
    logic [1:0]   next_irqStatus;
    logic [1:0]   tripEvent;
    logic [INPUTS-1:0] next_route;
    logic [INPUTS-1:0] next_power;
    virs_format_e next_format;
    logic [31:0]  next_readData;

    // ****************************************************************
    // Bus handshake: one wait cycle, answer on the second edge
    // ****************************************************************
    assign takeWrite = avWrite & ackPending;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ackPending <= 1'b0;
        end else begin
            ackPending <= (avRead | avWrite) & ~ackPending;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            avWaitRequest <= 1'b1;
        end else begin
            avWaitRequest <= ~((avRead | avWrite) & ~ackPending);
        end
    end

    // ****************************************************************
    // Configuration registers
    // ****************************************************************
    // [RQ1] format select field
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            inputFormatSelect <= `VIRS_RST_SELECT;
        end else if (takeWrite && avAddress == `VIRS_IDX_ROUTING) begin
            inputFormatSelect <= avWriteData[`VIRS_SEL_MSB:0];
        end
    end

    // ****************************************************************
    // Battery-short sense controls
    // ****************************************************************
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : gSense
            // [RQ10] [RQ14] power-off bit, reset off
            // [RQ11] [RQ13] threshold field, reset 011
            always_ff @(posedge mclk or negedge reset_n) begin
                if (!reset_n) begin
                    powerOff[g]  <= `VIRS_RST_PWR_OFF;
                    threshold[g] <= `VIRS_RST_THRESHOLD;
                end else if (takeWrite && avAddress == (g == 0 ? `VIRS_IDX_SENSE_ONE
                                                                : `VIRS_IDX_SENSE_TWO)) begin
                    powerOff[g]  <= avWriteData[`VIRS_PWR_OFF_BIT];
                    threshold[g] <= avWriteData[`VIRS_THR_MSB:`VIRS_THR_LSB];
                end
            end
            // [RQ7] [RQ9] [RQ12] trips only when powered
            assign tripEvent[g] = senseAboveThreshold[g] & ~powerOff[g];
        end
    endgenerate

    // ****************************************************************
    // Comparator control pins
    // ****************************************************************
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            sensePowerOff  <= {2{`VIRS_RST_PWR_OFF}};
            senseThreshold <= {2{`VIRS_RST_THRESHOLD}};
        end else begin
            sensePowerOff  <= powerOff;
            senseThreshold <= {threshold[1], threshold[0]};
        end
    end

    // ****************************************************************
    // Interrupt status, clear and enable
    // ****************************************************************
    assign clearHits = (takeWrite && avAddress == `VIRS_IDX_IRQ_CLEAR) ? avWriteData[1:0] : 2'h0;
    assign next_irqStatus = tripEvent | (irqStatus & ~clearHits);

    // [RQ8] sticky per-pin trip; set wins over clear
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            irqStatus <= 2'h0;
        end else begin
            irqStatus <= next_irqStatus;
        end
    end

    // [RQ9] enables reset cleared
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            irqEnable <= 2'h0;
        end else if (takeWrite && avAddress == `VIRS_IDX_IRQ_ENABLE) begin
            irqEnable <= avWriteData[1:0];
        end
    end

    // [RQ7] active-low interrupt pin
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            interrupt_request_n <= 1'b1;
        end else begin
            interrupt_request_n <= ~|(next_irqStatus & irqEnable);
        end
    end

    // ****************************************************************
    // Routing decode
    // ****************************************************************
    always_comb begin
        next_route  = '0;
        next_power  = '0;
        next_format = VIRS_FMT_NONE;
        case (inputFormatSelect)
            // [RQ2] code n on input n+1
            5'h00: begin
                next_format = VIRS_FMT_CVBS;
                next_route  = 8'h01;
            end
            5'h01: begin
                next_format = VIRS_FMT_CVBS;
                next_route  = 8'h02;
            end
            5'h02: begin
                next_format = VIRS_FMT_CVBS;
                next_route  = 8'h04;
            end
            5'h03: begin
                next_format = VIRS_FMT_CVBS;
                next_route  = 8'h08;
            end
            5'h04: begin
                next_format = VIRS_FMT_CVBS;
                next_route  = 8'h10;
            end
            5'h05: begin
                next_format = VIRS_FMT_CVBS;
                next_route  = 8'h20;
            end
            5'h06: begin
                next_format = VIRS_FMT_CVBS;
                next_route  = 8'h40;
            end
            5'h07: begin
                next_format = VIRS_FMT_CVBS;
                next_route  = 8'h80;
            end

            // [RQ3] luma and chroma pair
            `VIRS_SEL_SVIDEO: begin
                next_format = VIRS_FMT_SVIDEO;
                next_route  = 8'h03;
            end
            5'h09: begin
                next_format = VIRS_FMT_SVIDEO;
                next_route  = 8'h0c;
            end
            5'h0a: begin
                next_format = VIRS_FMT_SVIDEO;
                next_route  = 8'h30;
            end
            5'h0b: begin
                next_format = VIRS_FMT_SVIDEO;
                next_route  = 8'hc0;
            end

            // [RQ4] three consecutive inputs
            `VIRS_SEL_COMP: begin
                next_format = VIRS_FMT_COMP;
                next_route  = 8'h07;
            end
            5'h0d: begin
                next_format = VIRS_FMT_COMP;
                next_route  = 8'h38;
            end

            // [RQ5] odd positive, even negative
            `VIRS_SEL_DIFF: begin
                next_format = VIRS_FMT_DIFF;
                next_route  = 8'h03;
            end
            5'h0f: begin
                next_format = VIRS_FMT_DIFF;
                next_route  = 8'h0c;
            end
            5'h10: begin
                next_format = VIRS_FMT_DIFF;
                next_route  = 8'h30;
            end
            `VIRS_SEL_LAST_VALID: begin
                next_format = VIRS_FMT_DIFF;
                next_route  = 8'hc0;
            end

            // [RQ1] [RQ15] reserved codes route nothing
            default: begin
                next_format = VIRS_FMT_NONE;
                next_route  = '0;
            end
        endcase
        // [RQ15] reserved codes leave all off
        // [RQ6] unused channels powered down
        next_power = next_route;
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            routeToConverter <= '0;
            channelPowerOn   <= '0;
            processorFormat  <= VIRS_FMT_NONE;
        end else begin
            routeToConverter <= next_route;
            channelPowerOn   <= next_power;
            // [RQ6] processor follows format
            processorFormat  <= next_format;
        end
    end

    // ****************************************************************
    // Read data; unmapped offsets read zero
    // ****************************************************************
    always_comb begin
        next_readData = 32'h0;
        case (avAddress)
            `VIRS_IDX_ROUTING:     next_readData = {27'h0, inputFormatSelect};
            `VIRS_IDX_SENSE_ONE:   next_readData = {25'h0, powerOff[0], 1'b0, threshold[0], 2'h0};
            `VIRS_IDX_SENSE_TWO:   next_readData = {25'h0, powerOff[1], 1'b0, threshold[1], 2'h0};
            `VIRS_IDX_IRQ_STATUS:  next_readData = {30'h0, irqStatus};
            `VIRS_IDX_IRQ_ENABLE:  next_readData = {30'h0, irqEnable};
            `VIRS_IDX_ROUTE_STATE: next_readData = {21'h0, processorFormat, routeToConverter};
            default:               next_readData = 32'h0;
        endcase
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            avReadData <= 32'h0;
        end else if (avRead & ~ackPending) begin
            avReadData <= next_readData;
        end
    end
endmodule
`default_nettype wire

// ---- virs_control_properties.sv ----
/* Concurrent checks on the ports of virs_control.
   Assumes one clock domain and the bind statement at the foot of this file. */
`default_nettype none
module virs_chk
    import virs_pkg::*;
#(
    parameter int INPUTS = 8
) (
    input wire logic              mclk,
    input wire logic              reset_n,
    input wire logic [7:0]        avAddress,
    input wire logic              avRead,
    input wire logic              avWrite,
    input wire logic              avWaitRequest,
    input wire logic [1:0]        senseAboveThreshold,
    input wire logic [1:0]        sensePowerOff,
    input wire logic [5:0]        senseThreshold,
    input wire logic [INPUTS-1:0] channelPowerOn,
    input wire logic [INPUTS-1:0] routeToConverter,
    input wire virs_format_e      processorFormat,
    input wire logic              interrupt_request_n
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    // ********
    // Bus timing
    // ********
    a_wait_one: assert property ((avRead || avWrite) && avWaitRequest |=> !avWaitRequest)
        else $error("waitrequest not low one cycle after request");
    a_wait_pulse: assert property (!avWaitRequest |=> avWaitRequest)
        else $error("waitrequest low longer than one cycle");
    // ********
    // Routing and sense
    // ********
    a_irq_cause: assert property ($fell(interrupt_request_n) |->
        $past(|(senseAboveThreshold & ~sensePowerOff)) || $past(avWrite)
        || $past(|(senseAboveThreshold & ~sensePowerOff), 2) || $past(avWrite, 2))
        else $error("interrupt without powered trip or write");
    a_thr_write: assert property (!$stable(senseThreshold) |->
        $past(avWrite) || $past(avWrite, 2)) else $error("threshold moved without write");
    a_unused_off: assert property (channelPowerOn == routeToConverter)
        else $error("powered channels differ from routed ones");
    a_cvbs_one: assert property (processorFormat == VIRS_FMT_CVBS |->
        $onehot(routeToConverter)) else $error("composite route not one input");
    a_comp_triple: assert property (processorFormat == VIRS_FMT_COMP |->
        routeToConverter inside {8'h07, 8'h38}) else $error("component route wrong");
    a_diff_pair: assert property (processorFormat == VIRS_FMT_DIFF |->
        routeToConverter inside {8'h03, 8'h0c, 8'h30, 8'hc0}) else $error("diff route wrong");
    a_route_update: assert property ($changed(routeToConverter) |->
        !$past(reset_n) || !$past(reset_n, 2)
        || $past(avWrite && avAddress == 8'h00) || $past(avWrite && avAddress == 8'h00, 2))
        else $error("route changed without select write");
    c_irq: cover property (!interrupt_request_n);
    c_comp: cover property (processorFormat == VIRS_FMT_COMP);
    c_read: cover property (avRead && !avWaitRequest);
endmodule
bind virs_control virs_chk #(.INPUTS(INPUTS)) chk (
    .mclk                (mclk),
    .reset_n             (reset_n),
    .avAddress           (avAddress),
    .avRead              (avRead),
    .avWrite             (avWrite),
    .avWaitRequest       (avWaitRequest),
    .senseAboveThreshold (senseAboveThreshold),
    .sensePowerOff       (sensePowerOff),
    .senseThreshold      (senseThreshold),
    .channelPowerOn      (channelPowerOn),
    .routeToConverter    (routeToConverter),
    .processorFormat     (processorFormat),
    .interrupt_request_n (interrupt_request_n)
);
`default_nettype wire

// ---- testbench.sv ----
/* Self-checking bench for virs_control over Avalon-MM.
   Assumes package, header and checker compiled first. */
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import virs_pkg::*;
    logic         mclk, reset_n, avRead, avWrite, avWaitRequest, interrupt_request_n;
    logic [7:0]   avAddress, channelPowerOn, routeToConverter;
    logic [31:0]  avWriteData, avReadData, d;
    logic [1:0]   senseAboveThreshold, sensePowerOff;
    logic [5:0]   senseThreshold;
    logic [10:0]  expRoute;
    virs_format_e processorFormat;
    int           seed = 47954, bad_count = 0, n_compared = 0, cycles = 0;
    logic [31:0]  q[$];
    virs_control DUT (
        .mclk                (mclk),
        .reset_n             (reset_n),
        .avAddress           (avAddress),
        .avRead              (avRead),
        .avWrite             (avWrite),
        .avWriteData         (avWriteData),
        .avReadData          (avReadData),
        .avWaitRequest       (avWaitRequest),
        .senseAboveThreshold (senseAboveThreshold),
        .sensePowerOff       (sensePowerOff),
        .senseThreshold      (senseThreshold),
        .channelPowerOn      (channelPowerOn),
        .routeToConverter    (routeToConverter),
        .processorFormat     (processorFormat),
        .interrupt_request_n (interrupt_request_n)
    );
    task automatic check(input string what, input logic [31:0] e, input logic [31:0] s);
        n_compared++;
        if (s !== e) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, e, s);
        end
    endtask
    task automatic close_out();
        $display("compared %0d mismatched %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // Hold request until waitrequest seen low, then one idle edge
    task automatic bus(input logic rd, input logic [7:0] a, input logic [31:0] v);
        avAddress <= a;
        avWriteData <= v;
        avRead <= rd;
        avWrite <= !rd;
        @(posedge mclk);
        while (avWaitRequest !== 1'b0) @(posedge mclk);
        avRead <= 1'b0;
        avWrite <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        q.push_back(e);
        bus(1'b1, a, 32'h0);
    endtask
    task automatic trip(input logic [1:0] p);
        senseAboveThreshold <= p;
        @(posedge mclk);
        senseAboveThreshold <= 2'h0;
        @(posedge mclk);
    endtask
    function automatic logic [10:0] route_exp(input logic [4:0] c);
        if (c < 5'h08) return {VIRS_FMT_CVBS, 8'h01 << c};
        if (c < 5'h0c) return {VIRS_FMT_SVIDEO, 8'h03 << (2 * (c - 8))};
        if (c < 5'h0e) return {VIRS_FMT_COMP, 8'h07 << (3 * (c - 12))};
        if (c < 5'h12) return {VIRS_FMT_DIFF, 8'h03 << (2 * (c - 14))};
        return {VIRS_FMT_NONE, 8'h00};
    endfunction
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    // Watcher: every read answer takes the oldest note; also the hang limit
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            close_out();
        end
        if (avRead && avWaitRequest === 1'b0) check("read data", q.pop_front(), avReadData);
    end
    initial begin
        {reset_n, avRead, avWrite, senseAboveThreshold} = 5'h0;
        avAddress = 8'h00;
        avWriteData = 32'h0;
        repeat (10) @(posedge mclk);
        reset_n <= 1'b1;
        @(posedge mclk);
        rd(8'h5d, 32'h4c);
        rd(8'h5e, 32'h4c);
        rd(8'h72, 32'h0);
        rd(8'h73, 32'h101);
        check("irq pin", 32'h1, interrupt_request_n);
        $display("reset test done");
        for (int c = 0; c < 32; c++) begin
            d = $random(seed);
            bus(1'b0, 8'h00, {d[31:5], c[4:0]});
            rd(8'h00, {27'h0, c[4:0]});
            expRoute = route_exp(c[4:0]);
            rd(8'h73, {21'h0, expRoute});
            check("route pins", {24'h0, expRoute[7:0]}, routeToConverter);
            check("channel power", {24'h0, expRoute[7:0]}, channelPowerOn);
            check("format pins", {29'h0, expRoute[10:8]}, processorFormat);
        end
        $display("routing test done");
        for (int t = 0; t < 8; t++) begin
            d = $random(seed);
            bus(1'b0, 8'h5d, {d[31:7], 1'b0, d[5], t[2:0], d[1:0]});
            bus(1'b0, 8'h5e, {d[31:7], 1'b1, d[5], ~t[2:0], d[1:0]});
            rd(8'h5d, {27'h0, t[2:0], 2'h0});
            rd(8'h5e, {25'h0, 1'b1, 1'b0, ~t[2:0], 2'h0});
            check("threshold pins", {~t[2:0], t[2:0]}, senseThreshold);
            check("power pins", 32'h2, sensePowerOff);
        end
        $display("threshold test done");
        bus(1'b0, 8'h5d, 32'h4c);
        bus(1'b0, 8'h72, 32'h3);
        trip(2'h3);
        rd(8'h70, 32'h0);
        bus(1'b0, 8'h5d, 32'h0c);
        trip(2'h1);
        rd(8'h70, 32'h1);
        check("irq pin", 32'h0, interrupt_request_n);
        bus(1'b0, 8'h70, 32'hff);
        rd(8'h70, 32'h1);
        bus(1'b0, 8'h71, 32'h1);
        rd(8'h70, 32'h0);
        bus(1'b0, 8'h72, 32'h2);
        bus(1'b0, 8'h5e, 32'h0c);
        trip(2'h1);
        check("irq pin", 32'h1, interrupt_request_n);
        trip(2'h2);
        rd(8'h70, 32'h3);
        check("irq pin", 32'h0, interrupt_request_n);
        bus(1'b0, 8'h71, 32'h3);
        rd(8'h70, 32'h0);
        check("irq pin", 32'h1, interrupt_request_n);
        bus(1'b0, 8'h40, 32'hff);
        rd(8'h40, 32'h0);
        $display("interrupt test done");
        close_out();
    end
endmodule
`default_nettype wire
